// ===== logic/adcg_clock_ctrl.sv
// adcg_clock_ctrl: audio and dsp clock generation control
// assumes: xtal_clk is the 41.6 MHz crystal clock; the register port is on
// sys_clk; the reference pins are asynchronous to every clock here
`timescale 1ns/1ps
// Notes on behaviour
// - crystal clock is the reference for converters, tuner link and both plls
// - master mode uses crystal; slave mode locks to external-rate or host ws pin
// - master sample rate selectable: 44.1, 48 or 96 kHz
// - host word-select reference accepted at 44.1, 48 or 96 kHz
// - external-rate pin as direct source limited to 48 kHz or below
// - dsp pll clocks dsp cores and spdif; audio pll only audio references
// - each major block clock can be stopped by register
// - each host input and output picks full or half sample rate
// - tuner clock derived from crystal, 100 kHz or 400 kHz selectable
// - crystal divided by four before it feeds the dsp pll
// - dsp pll output post-divided by two, four or eight
// - dsp clock is 650 kHz times (212 + msel) over 2^(3 - dsp_sel)
// - after reset dsp pll settings give 130 MHz
// - slave reference dropout falls back to crystal at same target rate
module adcg_clock_ctrl #(
  parameter int DROPOUT_CYCLES = adcg_pkg::DROPOUT_CYC, // dropout timeout
  parameter int N_BLOCKS = 24 // gateable blocks
) (
  input wire logic sys_clk, // 40 MHz control clock
  input wire logic nrst, // async reset, low
  input wire logic xtal_clk, // crystal clock
  input wire logic pll_out_clk, // dsp pll vco output
  input wire logic [23:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic [23:0] reg_wdata, // write data
  output logic [23:0] reg_rdata, // read data
  input wire logic external_rate_ref, // external-rate pin
  input wire logic host_word_select_ref, // host word-select pin
  output logic [N_BLOCKS-1:0] block_clk, // gated dsp clocks per block
  output logic [7:0] pll_msel, // to dsp pll multiplier
  output logic xtal_ref_out, // crystal ref to converters and tuner link
  output logic pll_ref_clk, // crystal / 4 to dsp pll
  output logic [1:0] audio_ref_sel, // audio pll reference source
  output logic [1:0] audio_fs_sel, // targeted fs
  output logic [adcg_pkg::HOST_PORTS-1:0] host_half_fs, // per host port half fs
  output logic tuner_clk, // tuner communication clock
  output logic [23:0] analog_pd, // analog power-down bits
  output logic [31:0] dsp_clk_khz // computed dsp clock, kHz
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [23:0] clk_en, pll_ctrl;
  logic [1:0] hws_sync, ers_sync;
  logic [1:0] prediv;
  logic [2:0] post_cnt;
  logic post_clk;
  logic [1:0] dsp_sel_act;
  logic [31:0] drop_cnt;
  logic ref_lost;
  logic ref_prev;
  logic [7:0] tun_cnt;
  logic tun_q;
  logic [1:0] tun_sel_sync;
  logic [1:0] sel_q1, sel_q2, sel_q3;
  localparam logic [1:0] ADCG_XTAL_CODE = 2'(adcg_pkg::ADCG_SRC_XTAL);

  wire sel_pd = reg_addr == adcg_pkg::OFS_ANALOG_PD;
  wire sel_en = reg_addr == adcg_pkg::OFS_CLK_EN;
  wire sel_pll = reg_addr == adcg_pkg::OFS_PLL_CTRL;
  wire master_mode = ~pll_ctrl[adcg_pkg::MODE_BIT];
  wire use_extrate = pll_ctrl[adcg_pkg::SLVSRC_BIT];
  wire [1:0] fs_req = pll_ctrl[adcg_pkg::FS_LSB +: 2];
  wire [1:0] dsp_sel_req = pll_ctrl[adcg_pkg::DSPSEL_LSB +: 2];
  wire slave_ref = use_extrate ? ers_sync[1] : hws_sync[1];
  wire ref_edge = slave_ref & ~ref_prev;
  wire half_limit = (dsp_sel_req == 2'h3) ? 1'b0 : 1'b1;
  // rate code 3 is not a rate, so the previous one is kept
  wire [1:0] fs_keep = (fs_req <= adcg_pkg::FS_96K) ? fs_req : audio_fs_sel;
  wire extrate_slave = !master_mode && use_extrate;

  // ****************************************************************
  // register write and read
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      analog_pd <= adcg_pkg::ANALOG_PD_RST;
      clk_en <= adcg_pkg::CLK_EN_RST;
      pll_ctrl <= {14'h0000, adcg_pkg::DSPSEL_RST, adcg_pkg::MSEL_RST};
    end else if (reg_wr) begin
      if (sel_pd) analog_pd <= reg_wdata;
      if (sel_en) clk_en <= reg_wdata;
      if (sel_pll) pll_ctrl <= reg_wdata;
    end
  end
  // status: bit 23 of pll readback shows crystal fallback
  assign reg_rdata = sel_pd ? analog_pd :
                     sel_en ? clk_en :
                     sel_pll ? {ref_lost, pll_ctrl[22:0]} : 24'h00_0000;

  // ****************************************************************
  // pin synchronisers for slave references
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hws_sync <= 2'h0;
      ers_sync <= 2'h0;
      ref_prev <= 1'b0;
    end else begin
      hws_sync <= {hws_sync[0], host_word_select_ref};
      ers_sync <= {ers_sync[0], external_rate_ref};
      ref_prev <= slave_ref;
    end
  end

  // ****************************************************************
  // dropout watch: no rising edge for the timeout means the reference is gone
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drop_cnt <= 32'h0000_0000;
      ref_lost <= 1'b0;
    end else if (master_mode || ref_edge) begin
      drop_cnt <= 32'h0000_0000;
      ref_lost <= 1'b0;
    end else if (drop_cnt >= 32'(DROPOUT_CYCLES - 1)) begin
      ref_lost <= 1'b1;
    end else begin
      drop_cnt <= drop_cnt + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // audio pll source and rate; fallback keeps the same target fs
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      audio_ref_sel <= ADCG_XTAL_CODE;
      audio_fs_sel <= adcg_pkg::FS_44K1;
    end else begin
      if (master_mode || ref_lost) audio_ref_sel <= ADCG_XTAL_CODE;
      else if (use_extrate) audio_ref_sel <= 2'(adcg_pkg::ADCG_SRC_EXTRATE);
      else audio_ref_sel <= 2'(adcg_pkg::ADCG_SRC_HOSTWS);
      // extrate path cannot carry 96 kHz, clamp to 48 kHz, a kept rate too
      if (extrate_slave && fs_keep == adcg_pkg::FS_96K) begin
        audio_fs_sel <= adcg_pkg::FS_48K;
      end else begin
        audio_fs_sel <= fs_keep;
      end
    end
  end

  // per host port half fs
  assign host_half_fs = pll_ctrl[adcg_pkg::HOSTHALF_LSB +: adcg_pkg::HOST_PORTS];

  // ****************************************************************
  // crystal prescale by four for the dsp pll reference
  // ****************************************************************
  always_ff @(posedge xtal_clk or negedge nrst) begin
    if (!nrst) prediv <= 2'h0;
    else prediv <= prediv + 2'h1;
  end
  assign pll_ref_clk = prediv[1];
  assign xtal_ref_out = xtal_clk;

  // ****************************************************************
  // post divider; select changes only on the terminal count so the
  // output never sees a short pulse
  // ****************************************************************
  // the select word crosses from sys_clk: two flops, then a third so that
  // it is only taken when two settled samples agree
  always_ff @(posedge pll_out_clk or negedge nrst) begin
    if (!nrst) begin
      post_cnt <= 3'h0;
      dsp_sel_act <= adcg_pkg::DSPSEL_RST;
      sel_q1 <= adcg_pkg::DSPSEL_RST;
      sel_q2 <= adcg_pkg::DSPSEL_RST;
      sel_q3 <= adcg_pkg::DSPSEL_RST;
    end else begin
      post_cnt <= post_cnt + 3'h1;
      sel_q1 <= dsp_sel_req;
      sel_q2 <= sel_q1;
      sel_q3 <= sel_q2;
      if (post_cnt == 3'h7 && sel_q2 == sel_q3) dsp_sel_act <= sel_q3;
    end
  end
  // 11 -> /2, 10 -> /4, 01 and 00 -> /8
  always_comb begin
    unique case (dsp_sel_act)
      2'h3: post_clk = post_cnt[0];
      2'h2: post_clk = post_cnt[1];
      default: post_clk = post_cnt[2];
    endcase
  end

  // ****************************************************************
  // per block clock stop; dsp pll feeds dsp cores and spdif only
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < N_BLOCKS; gi++) begin : g_gate
      adcg_clk_gate u_gate (
        .clk_in(post_clk),
        .en(clk_en[gi]),
        .clk_out(block_clk[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // dsp clock figure for software readback
  // ****************************************************************
  assign pll_msel = pll_ctrl[adcg_pkg::MSEL_LSB +: adcg_pkg::MSEL_W];
  assign dsp_clk_khz = (32'(adcg_pkg::PLL_STEP_KHZ) * (32'(adcg_pkg::MSEL_OFFSET) + 32'(pll_msel)))
                       >> (2'h3 - dsp_sel_req);

  // ****************************************************************
  // tuner clock from crystal, 100 or 400 kHz
  // ****************************************************************
  // rate select comes from sys_clk, two flops before the divider reads it
  always_ff @(posedge xtal_clk or negedge nrst) begin
    if (!nrst) tun_sel_sync <= 2'h0;
    else tun_sel_sync <= {tun_sel_sync[0], pll_ctrl[adcg_pkg::TUNER_BIT]};
  end
  always_ff @(posedge xtal_clk or negedge nrst) begin
    if (!nrst) begin
      tun_cnt <= 8'h00;
      tun_q <= 1'b0;
    end else if (tun_cnt >= (tun_sel_sync[1] ? 8'(adcg_pkg::TUNER_400K_HALF - 1)
                             : 8'(adcg_pkg::TUNER_100K_HALF - 1))) begin
      tun_cnt <= 8'h00;
      tun_q <= ~tun_q;
    end else begin
      tun_cnt <= tun_cnt + 8'h01;
    end
  end
  assign tuner_clk = tun_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_reset_msel: assert property (@(posedge sys_clk) $rose(nrst) |-> pll_msel == 8'hBC && dsp_sel_req == 2'h2)
    else $error("dsp pll reset setting not 130 MHz");
  a_master_xtal: assert property (@(posedge sys_clk) disable iff (!nrst)
    master_mode ##1 master_mode |-> audio_ref_sel == ADCG_XTAL_CODE)
    else $error("master mode not on crystal");
  a_extrate_cap: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!master_mode && use_extrate) ##1 (!master_mode && use_extrate) |-> audio_fs_sel != adcg_pkg::FS_96K)
    else $error("extrate source above 48 kHz");
  a_fallback: assert property (@(posedge sys_clk) disable iff (!nrst)
    ref_lost |=> audio_ref_sel == ADCG_XTAL_CODE)
    else $error("no crystal fallback");
  a_fs_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
    (master_mode && fs_req != 2'h3) ##1 $stable(fs_req) |-> audio_fs_sel == $past(fs_req))
    else $error("fs not applied");
  a_host_half: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_pll |=> host_half_fs == $past(reg_wdata[23:16]))
    else $error("host half fs not written");
  a_clk_en_wr: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && sel_en |=> clk_en == $past(reg_wdata))
    else $error("clock enable write lost");
  a_formula: assert property (@(posedge sys_clk) disable iff (!nrst)
    dsp_sel_req == 2'h3 && half_limit == 1'b0 |-> dsp_clk_khz == 32'd650 * (32'd212 + 32'(pll_msel)))
    else $error("dsp clock formula wrong");
endmodule

// ===== pkg/adcg_pkg.sv
// adcg_pkg: constants for the audio/dsp clock generation control block
// assumes: one 40 MHz system clock domain, registers reached over a plain
// word port (address, write strobe, write data, read data)
package adcg_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [23:0] OFS_ANALOG_PD = 24'h00_0040;
  localparam logic [23:0] OFS_CLK_EN = 24'h00_0050;
  localparam logic [23:0] OFS_PLL_CTRL = 24'h00_0060;
  localparam int REG_W = 24;
  // ****************************************************************
  // pll_clock_control field layout
  // ****************************************************************
  localparam int MSEL_LSB = 0;
  localparam int MSEL_W = 8;
  localparam int DSPSEL_LSB = 8;
  localparam int MODE_BIT = 10;
  localparam int SLVSRC_BIT = 11;
  localparam int FS_LSB = 12;
  localparam int TUNER_BIT = 14;
  localparam int HOSTHALF_LSB = 16;
  localparam int HOST_PORTS = 8;
  // ****************************************************************
  // reset values; 188 with divider 10 gives 400 * 325 kHz = 130 MHz
  // ****************************************************************
  localparam logic [7:0] MSEL_RST = 8'hBC;
  localparam logic [1:0] DSPSEL_RST = 2'h2;
  localparam logic [23:0] CLK_EN_RST = 24'hFF_FFFF;
  localparam logic [23:0] ANALOG_PD_RST = 24'h00_0000;
  // ****************************************************************
  // dsp pll arithmetic
  // ****************************************************************
  localparam int MSEL_OFFSET = 212;
  localparam int PLL_STEP_KHZ = 650;
  localparam int XTAL_PREDIV = 4;
  localparam int XTAL_KHZ = 41600;
  // ****************************************************************
  // sample rate selects and reference sources
  // ****************************************************************
  localparam logic [1:0] FS_44K1 = 2'h0;
  localparam logic [1:0] FS_48K = 2'h1;
  localparam logic [1:0] FS_96K = 2'h2;
  typedef enum logic [1:0] {ADCG_SRC_XTAL, ADCG_SRC_HOSTWS, ADCG_SRC_EXTRATE} adcg_src_e;
  // ****************************************************************
  // tuner clock: 41.6 MHz / 416 = 100 kHz, / 104 = 400 kHz (half periods)
  // ****************************************************************
  localparam int TUNER_100K_HALF = 208;
  localparam int TUNER_400K_HALF = 52;
  // reference dropout timeout: 1 ms at 40 MHz system clock
  localparam int DROPOUT_US = 1000;
  localparam int SYS_MHZ = 40;
  localparam int DROPOUT_CYC = DROPOUT_US * SYS_MHZ;
endpackage

// ===== logic/adcg_clk_gate.sv
// adcg_clk_gate: glitch-free clock stop cell
// assumes: enable comes from logic clocked by sys_clk; gated clock is a
// divided or derived clock sampled in the same domain
`timescale 1ns/1ps
module adcg_clk_gate (
  input wire logic clk_in, // clock to gate
  input wire logic en, // enable, level
  output logic clk_out // gated clock
);
  logic en_lat;
  // ****************************************************************
  // latch enable while clock low so the gate never cuts a high phase
  // ****************************************************************
  always_latch begin
    if (!clk_in) begin
      en_lat <= en;
    end
  end
  assign clk_out = clk_in & en_lat;
endmodule

// ===== verif/adcg_ref_model.sv
// adcg_ref_model: crystal, dsp pll vco and audio reference pins
// assumes: reference pins run scaled fast so a short dropout count still sees edges
`timescale 1ns/1ps
module adcg_ref_model #(
  parameter real REF_HALF_NS = 400.0 // scaled reference half period
) (
  input wire logic ws_run, // host word-select toggles while high
  input wire logic ext_run, // external-rate pin toggles while high
  output logic xtal_clk, // crystal, 41.6 MHz
  output logic pll_out_clk, // dsp pll vco, 125 MHz
  output logic host_word_select_ref, // host word-select pin
  output logic external_rate_ref // external-rate pin
);
  // the crystal never stops, so it is the fallback of last resort
  initial begin
    xtal_clk = 1'b0;
    forever #12.019 xtal_clk = ~xtal_clk;
  end
  // vco free runs; 62.5 MHz after /2 keeps spdif within 660..2480 times 44.1 or 48 kHz
  initial begin
    pll_out_clk = 1'b0;
    forever #4 pll_out_clk = ~pll_out_clk;
  end
  // a stopped pin shows no edges at all, which is what a dropout looks like
  initial begin
    host_word_select_ref = 1'b0;
    external_rate_ref = 1'b0;
    forever begin
      #(REF_HALF_NS);
      if (ws_run) host_word_select_ref = ~host_word_select_ref;
      if (ext_run) external_rate_ref = ~external_rate_ref;
    end
  end
endmodule

// ===== verif/tb_adcg_clock_ctrl.sv
// tb_adcg_clock_ctrl: self-checking bench for the clock generation control
// assumes: partner model supplies crystal, vco and reference pins
`timescale 1ns/1ps
module tb_adcg_clock_ctrl;
  localparam int DROP = 50;
  logic sys_clk, nrst, reg_wr, ws_run, ext_run, xtal_clk, pll_out_clk, b;
  logic host_word_select_ref, external_rate_ref, xtal_ref_out, pll_ref_clk, tuner_clk;
  logic [23:0] reg_addr, reg_wdata, reg_rdata, analog_pd, block_clk, d;
  logic [7:0] pll_msel, host_half_fs, m, h;
  logic [1:0] audio_ref_sel, audio_fs_sel, s, f;
  logic [31:0] dsp_clk_khz;
  int mismatches, cmp_count, msrc, r, p;
  wire meas = (msrc == 0) ? tuner_clk : (msrc == 1) ? pll_ref_clk : block_clk[0];
  adcg_ref_model u_adcg_ref_model (.ws_run, .ext_run, .xtal_clk, .pll_out_clk, .host_word_select_ref,
    .external_rate_ref);
  adcg_clock_ctrl #(.DROPOUT_CYCLES(DROP)) u_adcg_clock_ctrl (.sys_clk, .nrst, .xtal_clk, .pll_out_clk,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .external_rate_ref, .host_word_select_ref, .block_clk,
    .pll_msel, .xtal_ref_out, .pll_ref_clk, .audio_ref_sel, .audio_fs_sel, .host_half_fs, .tuner_clk,
    .analog_pd, .dsp_clk_khz);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] khz(input logic [7:0] mm, input logic [1:0] ss);
    return 32'((adcg_pkg::PLL_STEP_KHZ * (adcg_pkg::MSEL_OFFSET + int'(mm))) >> (3 - int'(ss)));
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one-cycle strobe, then two edges so the derived outputs have landed
  task automatic wr(input logic [23:0] a, input logic [23:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [23:0] a, input logic [23:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    #1 check("reg_rdata", {8'h00, reg_rdata}, {8'h00, v});
  endtask
  // 1 ns polling, bounded so a dead clock ends the run
  task automatic lvl(input logic v);
    int n;
    n = 0;
    while (meas !== v && n < 20000) begin
      #1;
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      wrap_up();
    end
  endtask
  // period in ns, snapped to the expectation when within polling error
  task automatic per(input int src, input int exp, output int got);
    realtime t0;
    msrc = src;
    #1; // let the measured net follow the new source
    lvl(1'b0);
    lvl(1'b1);
    t0 = $realtime;
    lvl(1'b0);
    lvl(1'b1);
    got = int'($realtime - t0);
    got = (got > exp - 3 && got < exp + 3) ? exp : got;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 24'h00_0000;
    reg_wdata = 24'h00_0000;
    ws_run = 1'b1;
    ext_run = 1'b1;
    msrc = 0;
    mismatches = 0;
    cmp_count = 0;
    r = $urandom(32'h66a3_6c83);
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    // reset values, analog power-down and unmapped space
    rd(adcg_pkg::OFS_ANALOG_PD, 24'h00_0000);
    rd(adcg_pkg::OFS_CLK_EN, 24'hFF_FFFF);
    rd(adcg_pkg::OFS_PLL_CTRL, 24'h00_02BC);
    check("dsp_clk_khz", dsp_clk_khz, 32'h0001_FBD0);
    check("audio_ref_sel", {30'h0, audio_ref_sel}, 32'h0000_0000);
    d = 24'($urandom);
    wr(adcg_pkg::OFS_ANALOG_PD, d);
    wr(24'h00_0044, ~d);
    rd(adcg_pkg::OFS_ANALOG_PD, d);
    check("analog_pd", {8'h00, analog_pd}, {8'h00, d});
    rd(24'h00_0044, 24'h00_0000);
    // multiplier, divider, fs and host half-rate fields, corners first
    for (int i = 0; i < 12; i++) begin
      m = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      s = (i == 0) ? 2'h3 : (i == 1) ? 2'h0 : 2'($urandom);
      f = 2'($urandom % 3);
      h = 8'($urandom);
      wr(adcg_pkg::OFS_PLL_CTRL, {h, 2'h0, f, 2'h0, s, m});
      check("pll_msel", {24'h0, pll_msel}, {24'h0, m});
      check("dsp_clk_khz", dsp_clk_khz, khz(m, s));
      check("audio_fs_sel", {30'h0, audio_fs_sel}, {30'h0, f});
      check("host_half_fs", {24'h0, host_half_fs}, {24'h0, h});
      rd(adcg_pkg::OFS_PLL_CTRL, {1'b0, h[6:0], 2'h0, f, 2'h0, s, m});
    end
    // post-divider by two, four and eight on the block clocks
    for (int i = 0; i < 3; i++) begin
      s = (i == 0) ? 2'h3 : (i == 1) ? 2'h2 : 2'h0;
      wr(adcg_pkg::OFS_PLL_CTRL, {14'h0, s, 8'hBC});
      per(2, 16 << i, p);
      check("block_clk period", p, 16 << i);
    end
    // tuner clock rates, crystal prescaler and crystal passthrough
    wr(adcg_pkg::OFS_PLL_CTRL, 24'h00_02BC);
    per(0, 10000, p);
    check("tuner_clk period", p, 10000);
    wr(adcg_pkg::OFS_PLL_CTRL, 24'h00_42BC);
    per(0, 2500, p);
    check("tuner_clk period", p, 2500);
    per(1, 96, p);
    check("pll_ref_clk period", p, 96);
    for (int i = 0; i < 8; i++) begin
      #($urandom % 50 + 1);
      #0; // let the passthrough settle if a crystal edge lands in this step
      check("xtal_ref_out", {31'h0, xtal_ref_out}, {31'h0, xtal_clk});
    end
    // stopping one block clock and starting it again
    wr(adcg_pkg::OFS_CLK_EN, 24'hFF_FFFE);
    rd(adcg_pkg::OFS_CLK_EN, 24'hFF_FFFE);
    msrc = 2;
    b = block_clk[0];
    check("block_clk stop level", {31'h0, b}, 32'h0000_0000);
    for (int i = 0; i < 10; i++) begin
      #7 check("block_clk stopped", {31'h0, block_clk[0]}, {31'h0, b});
    end
    wr(adcg_pkg::OFS_CLK_EN, 24'hFF_FFFF);
    per(2, 32, p);
    check("block_clk restart", p, 32);
    // slave sources at every rate; the external-rate pin caps at 48 kHz
    for (int i = 0; i < 3; i++) begin
      f = 2'(i);
      wr(adcg_pkg::OFS_PLL_CTRL, {10'h000, f, 4'h6, 8'hBC});
      check("audio_ref_sel", {30'h0, audio_ref_sel}, 32'h0000_0001);
      check("audio_fs_sel", {30'h0, audio_fs_sel}, {30'h0, f});
      wr(adcg_pkg::OFS_PLL_CTRL, {10'h000, f, 4'hE, 8'hBC});
      check("audio_ref_sel", {30'h0, audio_ref_sel}, 32'h0000_0002);
      check("audio_fs_sel", {30'h0, audio_fs_sel}, (f == 2'h2) ? 32'h0000_0001 : {30'h0, f});
    end
    // rate code 3 keeps the previous rate, still capped on the external-rate pin
    wr(adcg_pkg::OFS_PLL_CTRL, 24'h00_22BC);
    check("audio_fs_sel", {30'h0, audio_fs_sel}, 32'h0000_0002);
    wr(adcg_pkg::OFS_PLL_CTRL, 24'h00_3EBC);
    check("audio_fs_sel", {30'h0, audio_fs_sel}, 32'h0000_0001);
    // word-select dropout falls back to the crystal at the same rate
    wr(adcg_pkg::OFS_PLL_CTRL, 24'h00_16BC);
    ws_run = 1'b0;
    repeat (DROP + 40) @(negedge sys_clk);
    check("audio_ref_sel", {30'h0, audio_ref_sel}, 32'h0000_0000);
    check("audio_fs_sel", {30'h0, audio_fs_sel}, 32'h0000_0001);
    rd(adcg_pkg::OFS_PLL_CTRL, 24'h80_16BC);
    ws_run = 1'b1;
    repeat (60) @(negedge sys_clk);
    check("audio_ref_sel", {30'h0, audio_ref_sel}, 32'h0000_0001);
    wrap_up();
  end
endmodule
